//--- irq_pkg.sv
// Shared constants, codes and carrier types of the interrupt controller
package irq_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] ADDR_ENABLE0    = 8'ha8;
    localparam logic [7:0] ADDR_ENABLE1    = 8'ha9;
    localparam logic [7:0] ADDR_PRIO_HIGH0 = 8'hb4;
    localparam logic [7:0] ADDR_PRIO_HIGH1 = 8'hb5;
    localparam logic [7:0] ADDR_PRIO_LOW0  = 8'hb8;
    localparam logic [7:0] ADDR_PRIO_LOW1  = 8'hb9;
    localparam logic [7:0] ADDR_EXT2_CTRL  = 8'he8;
    localparam logic [7:0] ADDR_STATUS     = 8'he9;

    ////////////////////////////////////////////////////////////////////////
    // Writable bits, reset value and field positions
    localparam logic [7:0] MASK_BANK0  = 8'h7f;
    localparam logic [7:0] MASK_BANK1  = 8'hbc;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam int GLOBAL_EN_BIT = 7;
    localparam int EXT2_TRIG_LSB = 2;
    localparam int EXT2_PEND_BIT = 0;
    localparam int STAT_NMI_BIT  = 7;
    localparam int STAT_RETI_BIT = 6;

    ////////////////////////////////////////////////////////////////////////
    // Sources, levels and timing in machine cycles
    localparam int NUM_SRC     = 12;
    localparam int SRC_EXT2    = 7;
    localparam int NUM_LEVELS  = 4;
    localparam int IDX_W       = 4;
    localparam int LVL_W       = 2;
    localparam int PC_W        = 16;
    localparam int CALL_CYCLES = 7;

    // Vector of each source, index equals same-level polling order
    localparam logic [PC_W-1:0] VECTOR [NUM_SRC] = '{
        16'h0003, 16'h000b, 16'h0013, 16'h001b,
        16'h0023, 16'h002b, 16'h0033, 16'h004b,
        16'h0053, 16'h005b, 16'h0063, 16'h0073
    };

    ////////////////////////////////////////////////////////////////////////
    // Enumerations
    typedef enum logic [1:0] {
        TRIG_LOW  = 2'b00,
        TRIG_FALL = 2'b01,
        TRIG_RISE = 2'b10,
        TRIG_BOTH = 2'b11
    } trig_mode_t;

    typedef enum logic [1:0] {
        CALL_IDLE = 2'b00,
        CALL_PUSH = 2'b01,
        CALL_LOAD = 2'b11
    } call_state_t;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_t;

    typedef struct packed {
        logic fetch;
        logic last_cycle;
        logic reti_exec;
    } cpu_in_t;

    typedef struct packed {
        logic            hold;
        logic            push_lo;
        logic            push_hi;
        logic            load_pc;
        logic [PC_W-1:0] vector;
    } cpu_out_t;

endpackage

//--- ext2_detect.sv
// Pin synchroniser and trigger detector for external interrupt 2
`timescale 1ns/1ns
module ext2_detect (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              ce,
    // Pin and mode
    input  wire logic              pin,
    input  wire irq_pkg::trig_mode_t mode,
    // Results
    output logic                   level_req,
    output logic                   edge_evt
);

    logic meta_reg;
    logic sync_reg;
    logic prev_reg;
    logic fall;
    logic rise;

    // Two stages before anything looks at the pin
    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            prev_reg <= 1'b1;
        end else if (ce) begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // Edges seen between consecutive machine-cycle samples
    assign fall      = prev_reg & ~sync_reg;
    assign rise      = ~prev_reg & sync_reg;
    assign level_req = (mode == irq_pkg::TRIG_LOW) & ~sync_reg;
    assign edge_evt  = ce & (((mode == irq_pkg::TRIG_FALL) & fall)
                     | ((mode == irq_pkg::TRIG_RISE) & rise)
                     | ((mode == irq_pkg::TRIG_BOTH) & (fall | rise)));

endmodule

//--- irq_controller.sv
// Four-level prioritised interrupt controller with hardware call sequencer
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
module irq_controller #(
    parameter int              CALL_CYCLES = irq_pkg::CALL_CYCLES,
    parameter logic [15:0]     NMI_VECTOR  = 16'h007b
) (
    // Clock, reset, enable
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic               ce,
    // Register port
    input  wire irq_pkg::bus_req_t  bus,
    output logic [7:0]              rdata,
    // Interrupt sources
    input  wire logic [11:0]        src_flag,
    input  wire logic               ext2_pin,
    input  wire logic               overload_nmi,
    // CPU sequencer
    input  wire irq_pkg::cpu_in_t   cpu_in,
    output irq_pkg::cpu_out_t       cpu_out,
    output logic [11:0]             flag_ack,
    output logic                    nmi_ack
);

    localparam int N = irq_pkg::NUM_SRC;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] LAST_PUSH = CNT_W'(CALL_CYCLES - 2);
    localparam logic [CNT_W-1:0] PUSH_HI_AT = CNT_W'(1);

    if (CALL_CYCLES < 3 || CALL_CYCLES > 15) begin : g_bad_cycles
        $error("CALL_CYCLES must lie between 3 and 15");
    end

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Spread a pair of bank registers onto source order
    function automatic logic [N-1:0] gather(input logic [7:0] b0,
                                            input logic [7:0] b1);
        gather = {b1[7], b1[5:2], b0[6:0]};
    endfunction

    // Best request: higher level wins, ties go to the lower index
    function automatic logic [6:0] arbitrate(input logic [N-1:0] req,
                                             input logic [N-1:0] hi,
                                             input logic [N-1:0] lo);
        logic       found;
        logic [1:0] best;
        logic [3:0] idx;
        found = 1'b0;
        best  = 2'b00;
        idx   = 4'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i] && (!found || {hi[i], lo[i]} >= best)) begin
                found = 1'b1;
                best  = {hi[i], lo[i]};
                idx   = 4'(i);
            end
        end
        arbitrate = {found, best, idx};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    logic [7:0]             enable0_reg;
    logic [7:0]             enable1_reg;
    logic [7:0]             prio_high0_reg;
    logic [7:0]             prio_high1_reg;
    logic [7:0]             prio_low0_reg;
    logic [7:0]             prio_low1_reg;
    irq_pkg::trig_mode_t    trig_reg;
    logic                   pend2_reg;
    logic                   pend2_next;
    logic [N-1:0]           sample_reg;
    logic                   nmi_sample_reg;
    logic                   win_valid_reg;
    logic [1:0]             win_lvl_reg;
    logic [3:0]             win_idx_reg;
    logic                   win_nmi_reg;
    logic [3:0]             in_prog_reg;
    logic [3:0]             in_prog_next;
    logic                   nmi_active_reg;
    logic                   reti_block_reg;
    irq_pkg::call_state_t   state_reg;
    irq_pkg::call_state_t   state_next;
    logic [CNT_W-1:0]       cnt_reg;
    logic [CNT_W-1:0]       cnt_next;
    logic [15:0]            vector_reg;
    logic [15:0]            vector_next;
    logic [7:0]             rdata_reg;
    irq_pkg::cpu_out_t      cpu_out_reg;
    irq_pkg::cpu_out_t      out_next;
    logic [N-1:0]           ack_reg;
    logic                   nmi_ack_reg;

    ////////////////////////////////////////////////////////////////////////
    // Register decode

    wire wr_en0   = bus.wr && bus.addr == irq_pkg::ADDR_ENABLE0;
    wire wr_en1   = bus.wr && bus.addr == irq_pkg::ADDR_ENABLE1;
    wire wr_ph0   = bus.wr && bus.addr == irq_pkg::ADDR_PRIO_HIGH0;
    wire wr_ph1   = bus.wr && bus.addr == irq_pkg::ADDR_PRIO_HIGH1;
    wire wr_pl0   = bus.wr && bus.addr == irq_pkg::ADDR_PRIO_LOW0;
    wire wr_pl1   = bus.wr && bus.addr == irq_pkg::ADDR_PRIO_LOW1;
    wire wr_ext2  = bus.wr && bus.addr == irq_pkg::ADDR_EXT2_CTRL;

    ////////////////////////////////////////////////////////////////////////
    // External interrupt 2

    logic ext2_level;
    logic ext2_edge;

    ext2_detect u_ext2 (
        .core_clk  (core_clk),
        .rst       (rst),
        .ce        (ce),
        .pin       (ext2_pin),
        .mode      (trig_reg),
        .level_req (ext2_level),
        .edge_evt  (ext2_edge)
    );

    // Level mode shows the synchronised pin, active low, edge mode the latched flag
    wire level_mode = trig_reg == irq_pkg::TRIG_LOW;
    wire ext2_flag  = level_mode ? ext2_level : pend2_reg;

    ////////////////////////////////////////////////////////////////////////
    // Requests and arbitration

    wire [N-1:0] src_en = gather(enable0_reg, enable1_reg)
                        & {N{enable0_reg[irq_pkg::GLOBAL_EN_BIT]}};
    wire [N-1:0] hi_bits = gather(prio_high0_reg, prio_high1_reg);
    wire [N-1:0] lo_bits = gather(prio_low0_reg, prio_low1_reg);
    wire [N-1:0] flags_all = {src_flag[N-1:irq_pkg::SRC_EXT2+1], ext2_flag,
                              src_flag[irq_pkg::SRC_EXT2-1:0]};
    wire [N-1:0] request = flags_all & src_en;
    wire [6:0]   winner  = arbitrate(sample_reg, hi_bits, lo_bits);

    ////////////////////////////////////////////////////////////////////////
    // Acceptance conditions

    // Highest in-progress bit is the preemption threshold
    wire       busy_any  = |in_prog_reg;
    wire [1:0] cur_level = in_prog_reg[3] ? 2'd3 : in_prog_reg[2] ? 2'd2 :
                           in_prog_reg[1] ? 2'd1 : 2'd0;
    // No maskable source passes while level three is in progress: nothing is strictly above it
    wire lvl_ok   = !busy_any || (win_lvl_reg > cur_level);
    // Request must still be live now; nothing stays latched while blocked
    wire still_on = win_nmi_reg ? overload_nmi
                                : request[win_idx_reg];
    wire prio_ok  = !nmi_active_reg
                  && (win_nmi_reg || (win_valid_reg && lvl_ok));
    wire go = ce && state_reg == irq_pkg::CALL_IDLE
            && cpu_in.last_cycle
            && !reti_block_reg && !cpu_in.reti_exec
            && still_on && prio_ok;

    // Edge-mode flag drops when its vector is taken
    wire ack_ext2 = go && !win_nmi_reg
                  && win_idx_reg == 4'(irq_pkg::SRC_EXT2);

    ////////////////////////////////////////////////////////////////////////
    // Call sequencer next state

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        unique case (state_reg)
            irq_pkg::CALL_IDLE: begin
                if (go) begin
                    state_next = irq_pkg::CALL_PUSH;
                    cnt_next   = '0;
                end
            end
            irq_pkg::CALL_PUSH: begin
                if (ce) begin
                    cnt_next = cnt_reg + CNT_W'(1);
                    if (cnt_reg == LAST_PUSH) begin
                        state_next = irq_pkg::CALL_LOAD;
                    end
                end
            end
            irq_pkg::CALL_LOAD: begin
                if (ce) begin
                    state_next = irq_pkg::CALL_IDLE;
                end
            end
            default: begin
                state_next = irq_pkg::CALL_IDLE;
            end
        endcase
    end

    // Vector chosen at the start of the call
    assign vector_next = !go ? vector_reg
                       : win_nmi_reg ? NMI_VECTOR
                       : irq_pkg::VECTOR[win_idx_reg];

    // Only the two PC bytes go to the stack, status word stays put
    assign out_next.hold    = state_next != irq_pkg::CALL_IDLE;
    assign out_next.push_lo = go;
    assign out_next.push_hi = state_next == irq_pkg::CALL_PUSH
                            && cnt_next == PUSH_HI_AT;
    assign out_next.load_pc = state_next == irq_pkg::CALL_LOAD;
    assign out_next.vector  = vector_next;

    // Return from interrupt retires the top active level first
    always_comb begin
        in_prog_next = in_prog_reg;
        if (cpu_in.reti_exec && !nmi_active_reg) begin
            if (in_prog_reg[3]) begin
                in_prog_next[3] = 1'b0;
            end else if (in_prog_reg[2]) begin
                in_prog_next[2] = 1'b0;
            end else if (in_prog_reg[1]) begin
                in_prog_next[1] = 1'b0;
            end else begin
                in_prog_next[0] = 1'b0;
            end
        end
        if (go && !win_nmi_reg) begin
            in_prog_next[win_lvl_reg] = 1'b1;
        end
    end

    // Pin event wins over a software clear in the same cycle
    assign pend2_next = ext2_edge ? 1'b1
                      : wr_ext2 ? bus.wdata[irq_pkg::EXT2_PEND_BIT]
                      : ack_ext2 && !level_mode ? 1'b0
                      : pend2_reg;

    ////////////////////////////////////////////////////////////////////////
    // Read mux, unmapped offsets read zero

    wire [7:0] ext2_view = {4'h0, trig_reg, 1'b0, ext2_flag};
    wire [7:0] status_view = {nmi_active_reg, reti_block_reg,
                              2'b00, in_prog_reg};
    wire [7:0] read_mux =
        bus.addr == irq_pkg::ADDR_ENABLE0    ? enable0_reg :
        bus.addr == irq_pkg::ADDR_ENABLE1    ? enable1_reg :
        bus.addr == irq_pkg::ADDR_PRIO_HIGH0 ? prio_high0_reg :
        bus.addr == irq_pkg::ADDR_PRIO_HIGH1 ? prio_high1_reg :
        bus.addr == irq_pkg::ADDR_PRIO_LOW0  ? prio_low0_reg :
        bus.addr == irq_pkg::ADDR_PRIO_LOW1  ? prio_low1_reg :
        bus.addr == irq_pkg::ADDR_EXT2_CTRL  ? ext2_view :
        bus.addr == irq_pkg::ADDR_STATUS     ? status_view : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Software registers; priority changes should be made with the
    // source disabled, since the high and low priority registers are written separately

    always_ff @(posedge core_clk) begin
        if (rst) begin
            enable0_reg    <= irq_pkg::RESET_VALUE;
            enable1_reg    <= irq_pkg::RESET_VALUE;
            prio_high0_reg <= irq_pkg::RESET_VALUE;
            prio_high1_reg <= irq_pkg::RESET_VALUE;
            prio_low0_reg  <= irq_pkg::RESET_VALUE;
            prio_low1_reg  <= irq_pkg::RESET_VALUE;
            trig_reg       <= irq_pkg::TRIG_LOW;
            pend2_reg      <= 1'b0;
        end else if (ce) begin
            if (wr_en0) begin
                enable0_reg <= bus.wdata;
            end
            if (wr_en1) begin
                enable1_reg <= bus.wdata & irq_pkg::MASK_BANK1;
            end
            if (wr_ph0) begin
                prio_high0_reg <= bus.wdata & irq_pkg::MASK_BANK0;
            end
            if (wr_ph1) begin
                prio_high1_reg <= bus.wdata & irq_pkg::MASK_BANK1;
            end
            if (wr_pl0) begin
                prio_low0_reg <= bus.wdata & irq_pkg::MASK_BANK0;
            end
            if (wr_pl1) begin
                prio_low1_reg <= bus.wdata & irq_pkg::MASK_BANK1;
            end
            if (wr_ext2) begin
                trig_reg <= irq_pkg::trig_mode_t'(
                    bus.wdata[irq_pkg::EXT2_TRIG_LSB +: 2]);
            end
            pend2_reg <= pend2_next;
        end
    end

    // Poll pipeline: sample on fetch, pick winner, act next cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sample_reg     <= '0;
            nmi_sample_reg <= 1'b0;
            win_valid_reg  <= 1'b0;
            win_lvl_reg    <= 2'b00;
            win_idx_reg    <= 4'h0;
            win_nmi_reg    <= 1'b0;
        end else if (ce) begin
            if (cpu_in.fetch) begin
                sample_reg     <= request;
                nmi_sample_reg <= overload_nmi;
            end
            win_valid_reg <= winner[6];
            win_lvl_reg   <= winner[5:4];
            win_idx_reg   <= winner[3:0];
            win_nmi_reg   <= nmi_sample_reg;
        end
    end

    // In-progress tracking; reti_exec clears the overload flag if set, else the top in-progress level bit
    always_ff @(posedge core_clk) begin
        if (rst) begin
            in_prog_reg    <= 4'h0;
            nmi_active_reg <= 1'b0;
            reti_block_reg <= 1'b0;
        end else if (ce) begin
            in_prog_reg <= in_prog_next;
            if (go && win_nmi_reg) begin
                nmi_active_reg <= 1'b1;
            end else if (cpu_in.reti_exec) begin
                nmi_active_reg <= 1'b0;
            end
            if (cpu_in.reti_exec) begin
                reti_block_reg <= 1'b1;
            end else if (cpu_in.last_cycle) begin
                reti_block_reg <= 1'b0;
            end
        end
    end

    // Sequencer and CPU-facing outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg   <= irq_pkg::CALL_IDLE;
            cnt_reg     <= '0;
            vector_reg  <= 16'h0000;
            cpu_out_reg <= '0;
            ack_reg     <= '0;
            nmi_ack_reg <= 1'b0;
        end else if (ce) begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            vector_reg  <= vector_next;
            cpu_out_reg <= out_next;
            ack_reg     <= (go && !win_nmi_reg)
                         ? N'(1) << win_idx_reg : '0;
            nmi_ack_reg <= go && win_nmi_reg;
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else if (ce) begin
            rdata_reg <= bus.rd ? read_mux : 8'h00;
        end
    end

    assign rdata    = rdata_reg;
    assign cpu_out  = cpu_out_reg;
    assign flag_ack = ack_reg;
    assign nmi_ack  = nmi_ack_reg;

endmodule

//--- irq_checker.sv
// Port assertions for the interrupt controller
`timescale 1ns/1ns
module irq_checker #(
    parameter int          CALL_CYCLES = 7,
    parameter logic [15:0] NMI_VECTOR  = 16'h007b
) (
    // Clock, reset and register port
    input logic              core_clk,
    input logic              rst,
    input logic              ce,
    input irq_pkg::bus_req_t bus,
    input logic [7:0]        rdata,
    // Sources and sequencer
    input logic [11:0]       src_flag,
    input logic              ext2_pin,
    input logic              overload_nmi,
    input irq_pkg::cpu_in_t  cpu_in,
    input irq_pkg::cpu_out_t cpu_out,
    input logic [11:0]       flag_ack,
    input logic              nmi_ack
);
    localparam int TAIL = CALL_CYCLES - 2;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Index of a one-hot acknowledge
    function automatic int ack_idx(input logic [11:0] a);
        ack_idx = 0;
        for (int i = 0; i < 12; i++)
            if (a[i]) ack_idx = i;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Call steps after the low byte push: high byte, then vector load
    sequence call_tail;
        ##1 cpu_out.push_hi ##TAIL cpu_out.load_pc;
    endsequence

    call_order_a: assert property (cpu_out.push_lo |-> call_tail)
        else $error("call steps out of order");
    hold_len_a: assert property ($rose(cpu_out.hold) |-> cpu_out.hold [*7] ##1 !cpu_out.hold)
        else $error("hold length wrong");
    ack_one_a: assert property (cpu_out.push_lo |-> $onehot(flag_ack) != nmi_ack)
        else $error("acknowledge not one-hot");
    vector_map_a: assert property ((|flag_ack) |-> cpu_out.vector == irq_pkg::VECTOR[ack_idx(flag_ack)])
        else $error("vector does not match source");
    nmi_vector_a: assert property (nmi_ack |-> cpu_out.vector == NMI_VECTOR && flag_ack == 12'h000)
        else $error("overload vector wrong");
    instr_end_a: assert property (cpu_out.push_lo |-> $past(cpu_in.last_cycle) && !$past(cpu_in.reti_exec))
        else $error("call started mid-instruction");
    flag_live_a: assert property ((|(flag_ack & 12'hf7f)) |-> (|($past(src_flag) & flag_ack)))
        else $error("call for a vanished flag");
    rdata_idle_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
        else $error("read data outside its slot");
endmodule

bind irq_controller irq_checker #(.CALL_CYCLES(CALL_CYCLES), .NMI_VECTOR(NMI_VECTOR)) chk (
    .core_clk, .rst, .ce, .bus, .rdata, .src_flag, .ext2_pin, .overload_nmi, .cpu_in, .cpu_out, .flag_ack, .nmi_ack);

//--- cpu_partner.sv
// Behavioural CPU sequencer and peripheral flag sources
`timescale 1ns/1ns
module cpu_partner (
    // Clock and reset
    input  logic             core_clk,
    input  logic             rst,
    // Bench commands
    input  logic             slow,
    input  logic             reti_req,
    input  logic [11:0]      set_mask,
    input  logic [11:0]      drop_mask,
    // Controller side
    input  logic [11:0]      flag_ack,
    output logic [11:0]      src_flag,
    output irq_pkg::cpu_in_t cpu_in
);
    logic [1:0] step_reg;

    // Slow mode stretches each instruction to four cycles and fetches only in the first
    assign cpu_in.fetch      = !slow || step_reg == 2'h0;
    assign cpu_in.last_cycle = step_reg == 2'h3;
    assign cpu_in.reti_exec  = reti_req;

    ////////////////////////////////////////////////////////////////////////
    // Flags stay up until acknowledged or dropped, like a real peripheral
    always_ff @(posedge core_clk) begin
        if (rst) begin
            step_reg <= 2'h3;
            src_flag <= 12'h000;
        end else begin
            step_reg <= slow ? step_reg + 2'h1 : 2'h3;
            src_flag <= (src_flag | set_mask) & ~flag_ack & ~drop_mask;
        end
    end
endmodule

//--- tb.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/1ns
module tb;
    logic              core_clk;
    logic              rst = 1'b1;
    logic              slow = 1'b0;
    logic              reti_req = 1'b0;
    logic              ext2_pin = 1'b1;
    logic              overload_nmi = 1'b0;
    logic              nmi_ack;
    logic [7:0]        rdata;
    logic [11:0]       src_flag;
    logic [11:0]       flag_ack;
    logic [11:0]       set_mask = 12'h000;
    logic [11:0]       drop_mask = 12'h000;
    logic [15:0]       exp_q[$];
    logic [31:0]       seed = 32'hdb3c;
    logic [7:0]        addrs[7] = '{8'ha8, 8'ha9, 8'hb4, 8'hb5, 8'hb8, 8'hb9, 8'h00};
    logic [7:0]        masks[7] = '{8'hff, 8'hbc, 8'h7f, 8'hbc, 8'h7f, 8'hbc, 8'h00};
    irq_pkg::bus_req_t bus = '0;
    irq_pkg::cpu_in_t  cpu_in;
    irq_pkg::cpu_out_t cpu_out;
    int                n_errors;
    int                checks_done;
    int                calls;
    int                pushed;
    int                lat;

    irq_controller DUT (.core_clk, .rst, .ce(1'b1), .bus, .rdata, .src_flag, .ext2_pin, .overload_nmi,
        .cpu_in, .cpu_out, .flag_ack, .nmi_ack);
    cpu_partner cpu (.core_clk, .rst, .slow, .reti_req, .set_mask, .drop_mask, .flag_ack, .src_flag, .cpu_in);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // A gap cycle after each strobe keeps every signal to one assignment per step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus <= '0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus <= '0;
        @(posedge core_clk);
        chk({8'h00, rdata}, {8'h00, e});
    endtask
    task automatic push(input logic [15:0] v);
        exp_q.push_back(v);
        pushed++;
    endtask
    // One command cycle, then a window long enough for any call to finish
    task automatic step(input logic [11:0] s, input logic [11:0] d, input logic r);
        set_mask <= s;
        drop_mask <= d;
        reti_req <= r;
        @(posedge core_clk);
        set_mask <= 12'h000;
        drop_mask <= 12'h000;
        reti_req <= 1'b0;
        repeat (20) @(posedge core_clk);
        chk(16'(calls), 16'(pushed));
    endtask

    // Model check: every call must be the next expected vector
    always @(negedge core_clk) begin
        if (cpu_out.push_lo === 1'b1) begin
            calls++;
            chk(cpu_out.vector, exp_q.size() != 0 ? exp_q.pop_front() : 16'hxxxx);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd(8'he8, 8'h00);
        wr(8'he8, 8'h0d);
        rd(8'he8, 8'h0d);
        wr(8'he8, 8'h04);
        rd(8'he8, 8'h04);
        foreach (addrs[i]) begin
            rd(addrs[i], 8'h00);
            seed = lfsr(seed);
            wr(addrs[i], seed[7:0]);
            rd(addrs[i], seed[7:0] & masks[i]);
            wr(addrs[i], 8'h00);
        end
        wr(8'hb8, 8'h02);
        wr(8'ha8, 8'h83);
        push(16'h000b);
        set_mask <= 12'h003;
        @(posedge core_clk);
        set_mask <= 12'h000;
        lat = 1;
        while (calls < pushed && lat < 40) begin
            @(posedge core_clk);
            lat++;
        end
        chk(16'(lat), 16'h0005);
        if (lat == 40) end_sim();
        step(12'h000, 12'h000, 1'b0);
        push(16'h0003);
        step(12'h000, 12'h000, 1'b1);
        step(12'h000, 12'h000, 1'b1);
        wr(8'ha8, 8'h00);
        wr(8'hb8, 8'h00);
        wr(8'ha8, 8'h83);
        push(16'h0003);
        step(12'h003, 12'h000, 1'b0);
        push(16'h000b);
        step(12'h000, 12'h000, 1'b1);
        step(12'h000, 12'h000, 1'b1);
        push(16'h0003);
        step(12'h003, 12'h000, 1'b0);
        step(12'h000, 12'h002, 1'b0);
        step(12'h000, 12'h000, 1'b1);
        push(16'h007b);
        overload_nmi <= 1'b1;
        step(12'h000, 12'h000, 1'b0);
        overload_nmi <= 1'b0;
        step(12'h000, 12'h000, 1'b1);
        wr(8'ha9, 8'h04);
        slow <= 1'b1;
        for (int m = 1; m < 4; m++) begin
            wr(8'he8, 8'(m << 2));
            if (m != 2) push(16'h004b);
            ext2_pin <= 1'b0;
            step(12'h000, 12'h000, 1'b0);
            step(12'h000, 12'h000, 1'b1);
            if (m != 1) push(16'h004b);
            ext2_pin <= 1'b1;
            step(12'h000, 12'h000, 1'b0);
            step(12'h000, 12'h000, 1'b1);
            rd(8'he8, 8'(m << 2));
        end
        wr(8'he8, 8'h00);
        push(16'h004b);
        ext2_pin <= 1'b0;
        step(12'h000, 12'h000, 1'b0);
        rd(8'he8, 8'h01);
        ext2_pin <= 1'b1;
        step(12'h000, 12'h000, 1'b1);
        rd(8'he8, 8'h00);
        end_sim();
    end
endmodule
